// [core/fmu_pkg.sv]
package fmu_pkg;
	// operation select on the dispatch port
	typedef enum logic [1:0] {
		FMU_MUL_DOUBLE_FP,
		FMU_MUL_SINGLE_FP,
		FMU_MUL_INT_LOW_WORD,
		FMU_MUL_INT_FULL_PAIR
	} fmu_op_t;
	// operand-read sequencer, one state per execute cycle
	typedef enum logic [1:0] {FMU_IDLE, FMU_E2, FMU_E3, FMU_E4} fmu_st_t;
	typedef struct packed {
		logic vld;
		fmu_op_t op;
		logic cond;
		logic [4:0] dst;
		logic use_cst;
		logic [4:0] cst5;
	} fmu_issue_t;
	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} fmu_wb_t;
	// status / mask layout: bit0 invalid, bit1 inexact, bit2 den1, bit3 den2
	typedef struct packed {
		logic denormal_source_flag2;
		logic denormal_source_flag1;
		logic inexact_flag;
		logic invalid_op_flag;
	} fmu_flags_t;
	typedef struct packed {
		logic vld;
		logic [4:0] idx;
		logic [31:0] data;
		fmu_flags_t flg;
	} fmu_slot_t;
	typedef struct packed {
		logic sgn;
		logic zero;
		logic den;
		logic inf;
		logic nan;
		logic signalling_nan;
		logic signed [12:0] exp;
		logic [52:0] man;
	} fmu_unp_t;
	typedef struct packed {
		logic [63:0] res;
		fmu_flags_t flg;
	} fmu_fres_t;
	// register port
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] STATUS_RST = 4'h0;
	localparam logic [3:0] MASK_RST = 4'h0;
	// special values
	localparam logic [31:0] NAN_SP = 32'h7fff_ffff;
	localparam logic [63:0] NAN_DP = 64'h7fff_ffff_ffff_ffff;
	localparam logic [30:0] INF_SP = 31'h7f80_0000;
	localparam logic [62:0] INF_DP = 63'h7ff0_0000_0000_0000;
	localparam logic signed [12:0] BIAS_SP = 13'sh007f;
	localparam logic signed [12:0] BIAS_DP = 13'sh03ff;
	localparam logic signed [12:0] EOVF_SP = 13'sh00ff;
	localparam logic signed [12:0] EOVF_DP = 13'sh07ff;
	localparam logic [6:0] SH_SP = 7'h52;
	localparam logic [6:0] SH_DP = 7'h35;
	// write-slot timing: slot k leaves as a write k+2 cycles after insertion
	localparam int SLOT_N = 8;
	localparam logic [2:0] K_SP = 3'h1;
	localparam logic [2:0] K_INT_LO = 3'h6;
	localparam logic [2:0] K_INT_HI = 3'h7;
	localparam logic [2:0] K_DP_LO = 3'h3;
	localparam logic [2:0] K_DP_HI = 3'h4;
endpackage : fmu_pkg

// [core/fmu_top.sv]
// Functional notes
// - any NaN source gives the canonical NaN result, single and double.
// - canonical NaN sign is the xor of both source signs.
// - a signalling NaN source also raises the invalid flag.
// - infinity times infinity or nonzero normal gives correctly signed infinity.
// - zero times infinity gives signed NaN and raises invalid.
// - zero times finite non-NaN gives signed zero.
// - denormal source is read as zero and sets its position's denormal flag.
// - denormal sets inexact unless other is infinity, NaN or zero.
// - rounding the product sets the inexact flag.
// - double multiply busy four cycles, writes low word E9, high word E10.
// - low word leads high word, so double consumers gain one slot.
// - single multiply reads in E1, busy one cycle, writes in E4.
// - low-word integer multiply writes low 32 bits of signed product.
// - low-word integer multiply busy four cycles, writes in E9.
// - full integer product goes low to even, high to odd register.
// - full integer multiply writes low in E9, high in E10.
`timescale 1ns/100ps
module fmu_top
	import fmu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// dispatch and operand read ports
	input wire fmu_issue_t iss,
	input wire logic [31:0] src1,
	input wire logic [31:0] src2,
	output fmu_st_t st_ff,
	output logic busy_ff,
	// register-file write port
	output fmu_wb_t wb_ff,
	// status register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_ff,
	output logic irq_ff
);

	// classify one operand; single values are widened to the double layout
	function automatic fmu_unp_t unpack(input logic [63:0] v, input logic sp);
		fmu_unp_t u;
		logic [10:0] e;
		logic [51:0] f;
		logic emax;
		if (sp)
		begin
			e = {3'h0, v[30:23]};
			f = {v[22:0], 29'h0};
			emax = (v[30:23] == 8'hff);
			u.sgn = v[31];
		end
		else
		begin
			e = v[62:52];
			f = v[51:0];
			emax = (e == 11'h7ff);
			u.sgn = v[63];
		end
		u.zero = (e == 11'h000) && (f == 52'h0);
		u.den = (e == 11'h000) && (f != 52'h0);
		u.inf = emax && (f == 52'h0);
		u.nan = emax && (f != 52'h0);
		u.signalling_nan = u.nan && !f[51];
		u.exp = $signed({2'b00, e}) - (sp ? BIAS_SP : BIAS_DP);
		u.man = {1'b1, f};
		return u;
	endfunction : unpack

	// full multiply with specials, round to nearest even, flush on underflow
	function automatic fmu_fres_t fmul(input logic [63:0] a, input logic [63:0] b, input logic sp);
		fmu_fres_t r;
		fmu_unp_t ua;
		fmu_unp_t ub;
		logic s;
		logic za;
		logic zb;
		logic [105:0] p;
		logic [105:0] rem;
		logic [105:0] half;
		logic [6:0] sh;
		logic [53:0] sig;
		logic up;
		logic carry;
		logic signed [12:0] be;
		logic hi;
		ua = unpack(a, sp);
		ub = unpack(b, sp);
		s = ua.sgn ^ ub.sgn;
		za = ua.zero || ua.den;
		zb = ub.zero || ub.den;
		r.flg = '0;
		r.flg.denormal_source_flag1 = ua.den;
		r.flg.denormal_source_flag2 = ub.den;
		p = ua.man * ub.man;
		hi = p[105]; // two leading ones may reach two, worth one exponent step
		if (!p[105])
		begin
			p = {p[104:0], 1'b0};
		end
		sh = sp ? SH_SP : SH_DP;
		sig = 54'(p >> sh);
		rem = p & ((106'h1 << sh) - 106'h1);
		half = 106'h1 << (sh - 7'h1);
		up = (rem > half) || ((rem == half) && sig[0]);
		sig = sig + 54'(up);
		carry = sp ? sig[24] : sig[53];
		be = ua.exp + ub.exp + (sp ? BIAS_SP : BIAS_DP) + 13'(hi) + 13'(carry);
		if (ua.nan || ub.nan)
		begin
			r.res = sp ? {32'h0, s, NAN_SP[30:0]} : {s, NAN_DP[62:0]};
			r.flg.invalid_op_flag = ua.signalling_nan || ub.signalling_nan;
		end
		else if ((za && ub.inf) || (zb && ua.inf))
		begin
			// zero, or denormal read as zero, against infinity
			r.res = sp ? {32'h0, s, NAN_SP[30:0]} : {s, NAN_DP[62:0]};
			r.flg.invalid_op_flag = 1'b1;
		end
		else if (ua.inf || ub.inf)
		begin
			r.res = sp ? {32'h0, s, INF_SP} : {s, INF_DP};
		end
		else if (za || zb)
		begin
			r.res = sp ? {32'h0, s, 31'h0} : {s, 63'h0};
			r.flg.inexact_flag = (ua.den && !ub.zero) || (ub.den && !ua.zero);
		end
		else if (be >= (sp ? EOVF_SP : EOVF_DP))
		begin
			// overflow saturates to infinity and is always inexact
			r.res = sp ? {32'h0, s, INF_SP} : {s, INF_DP};
			r.flg.inexact_flag = 1'b1;
		end
		else if (be <= 13'sh0000)
		begin
			// tiny results flush to zero; no subnormal output is built
			r.res = sp ? {32'h0, s, 31'h0} : {s, 63'h0};
			r.flg.inexact_flag = 1'b1;
		end
		else
		begin
			r.res = sp ? {32'h0, s, be[7:0], sig[22:0]} : {s, be[10:0], sig[51:0]};
			r.flg.inexact_flag = (rem != 106'h0);
		end
		return r;
	endfunction : fmul

	fmu_st_t nxt_st;
	fmu_op_t op_ff;
	logic cond_ff;
	logic [4:0] dst_ff;
	logic [31:0] lo1_ff;
	logic [31:0] lo2_ff;
	fmu_slot_t slot_ff [SLOT_N];
	fmu_slot_t nxt_slot [SLOT_N];
	fmu_flags_t status_ff;
	fmu_flags_t mask_ff;
	fmu_flags_t nxt_status;
	fmu_flags_t nxt_mask;
	fmu_flags_t clr;
	fmu_flags_t set;

	// dispatch decode
	logic acc;
	logic is_sp;
	logic is_dp;
	logic is_full;
	logic [31:0] op1;
	logic signed [63:0] iprod;
	fmu_fres_t sp_fr;
	fmu_fres_t db_fr;
	assign acc = iss.vld && (st_ff == FMU_IDLE);
	assign is_sp = (iss.op == FMU_MUL_SINGLE_FP);
	assign is_dp = (iss.op == FMU_MUL_DOUBLE_FP);
	assign is_full = (iss.op == FMU_MUL_INT_FULL_PAIR);
	assign op1 = iss.use_cst ? {{27{iss.cst5[4]}}, iss.cst5} : src1;
	assign iprod = $signed(op1) * $signed(src2);
	assign sp_fr = fmul({32'h0, src1}, {32'h0, src2}, 1'b1);
	// double sources: low halves held from E1, high halves read live in E4
	assign db_fr = fmul({src1, lo1_ff}, {src2, lo2_ff}, 1'b0);

	// slot insertions; a false predicate inserts nothing
	// colliding inserts are not arbitrated: the dispatcher keeps write slots apart
	logic ia_go;
	logic ia_hi_go;
	logic db_go;
	logic [2:0] ia_k;
	fmu_slot_t ia_lo;
	fmu_slot_t ia_hi;
	fmu_slot_t db_lo;
	fmu_slot_t db_hi;
	assign ia_go = acc && iss.cond && !is_dp;
	assign ia_hi_go = ia_go && is_full;
	assign db_go = (st_ff == FMU_E4) && (op_ff == FMU_MUL_DOUBLE_FP) && cond_ff;
	assign ia_k = is_sp ? K_SP : K_INT_LO;
	assign ia_lo.vld = 1'b1;
	assign ia_lo.idx = is_full ? {iss.dst[4:1], 1'b0} : iss.dst;
	assign ia_lo.data = is_sp ? sp_fr.res[31:0] : iprod[31:0];
	assign ia_lo.flg = is_sp ? sp_fr.flg : '0;
	assign ia_hi = {1'b1, iss.dst[4:1], 1'b1, iprod[63:32], 4'h0};
	// flags ride with the low word, the first one written
	assign db_lo = {1'b1, dst_ff[4:1], 1'b0, db_fr.res[31:0], db_fr.flg};
	assign db_hi = {1'b1, dst_ff[4:1], 1'b1, db_fr.res[63:32], 4'h0};

	// write-slot line: each slot shifts one step toward the port per cycle
	for (genvar i = 0; i < SLOT_N; i++)
	begin : g_slot
		fmu_slot_t shf;
		if (i == SLOT_N - 1)
		begin : g_end
			assign shf = '0;
		end
		else
		begin : g_mid
			assign shf = slot_ff[i+1];
		end
		assign nxt_slot[i] = (ia_go && (3'(i) == ia_k)) ? ia_lo :
			(ia_hi_go && (3'(i) == K_INT_HI)) ? ia_hi :
			(db_go && (3'(i) == K_DP_LO)) ? db_lo :
			(db_go && (3'(i) == K_DP_HI)) ? db_hi : shf;
	end

	// sequencer: multi-cycle ops hold the unit for E1..E4
	always_comb
	begin
		case (st_ff)
			FMU_IDLE: nxt_st = (acc && !is_sp) ? FMU_E2 : FMU_IDLE;
			FMU_E2: nxt_st = FMU_E3;
			FMU_E3: nxt_st = FMU_E4;
			FMU_E4: nxt_st = FMU_IDLE;
			default: nxt_st = FMU_IDLE;
		endcase
	end

	// status bits: hardware set wins over a write-one clear in the same cycle
	assign clr = (reg_wr && (reg_addr == REG_STATUS)) ? fmu_flags_t'(reg_wdata[3:0]) : '0;
	assign set = slot_ff[0].vld ? slot_ff[0].flg : '0;
	assign nxt_status = (status_ff & ~clr) | set;
	assign nxt_mask = (reg_wr && (reg_addr == REG_MASK)) ? fmu_flags_t'(reg_wdata[3:0]) : mask_ff;

	// register read mux; unmapped offsets read zero
	logic [31:0] rd_mux;
	assign rd_mux = (reg_addr == REG_STATUS) ? {28'h0, status_ff} :
		(reg_addr == REG_MASK) ? {28'h0, mask_ff} : 32'h0;

	// sequencer and operand capture
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff <= FMU_IDLE;
			busy_ff <= 1'b0;
			op_ff <= FMU_MUL_DOUBLE_FP;
			cond_ff <= 1'b0;
			dst_ff <= 5'h00;
			lo1_ff <= 32'h0000_0000;
			lo2_ff <= 32'h0000_0000;
		end
		else
		begin
			st_ff <= nxt_st;
			busy_ff <= (nxt_st != FMU_IDLE);
			if (acc)
			begin
				op_ff <= iss.op;
				cond_ff <= iss.cond;
				dst_ff <= iss.dst;
				lo1_ff <= src1;
				lo2_ff <= src2;
			end
		end
	end

	// write slots and the registered write port
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int j = 0; j < SLOT_N; j++)
			begin
				slot_ff[j] <= '0;
			end
			wb_ff <= '0;
		end
		else
		begin
			slot_ff <= nxt_slot;
			wb_ff <= {slot_ff[0].vld, slot_ff[0].idx, slot_ff[0].data};
		end
	end

	// status, mask, interrupt and read data
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			status_ff <= STATUS_RST;
			mask_ff <= MASK_RST;
			irq_ff <= 1'b0;
			reg_rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			irq_ff <= |(nxt_status & nxt_mask);
			reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// operand classes for the checks below; the double ones are valid in E4 only
	fmu_unp_t sp_ua;
	fmu_unp_t sp_ub;
	fmu_unp_t db_ua;
	fmu_unp_t db_ub;
	assign sp_ua = unpack({32'h0, src1}, 1'b1);
	assign sp_ub = unpack({32'h0, src2}, 1'b1);
	assign db_ua = unpack({src1, lo1_ff}, 1'b0);
	assign db_ub = unpack({src2, lo2_ff}, 1'b0);

	// pipeline timing, predicate, NaN and denormal-flag checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sp_write_a: assert property (acc && iss.cond && is_sp |-> ##3 wb_ff.en && wb_ff.idx == $past(iss.dst, 3))
		else $error("single multiply write not in E4");
	int_write_a: assert property (acc && iss.cond && iss.op == FMU_MUL_INT_LOW_WORD |-> ##8 wb_ff.en)
		else $error("integer low-word write not in E9");
	dp_write_a: assert property (acc && iss.cond && is_dp |-> ##8 (wb_ff.en && !wb_ff.idx[0]) ##1 (wb_ff.en && wb_ff.idx[0]))
		else $error("double multiply words not in E9 and E10");
	pair_order_a: assert property (acc && iss.cond && is_full |-> ##8 wb_ff.idx == {$past(iss.dst[4:1], 8), 1'b0}
		##1 wb_ff.idx == {$past(iss.dst[4:1], 9), 1'b1})
		else $error("full integer product pair order wrong");
	unit_busy_a: assert property (acc && !is_sp |=> busy_ff [*3] ##1 !busy_ff)
		else $error("unit occupancy not four cycles");
	no_pred_a: assert property (acc && !iss.cond && is_sp && !(|set) && !slot_ff[1].vld && !slot_ff[2].vld
		&& st_ff == FMU_IDLE |=> !nxt_slot[0].vld)
		else $error("predicated-off multiply wrote a result");
	nan_sign_a: assert property (acc && is_sp && (sp_ua.nan || sp_ub.nan)
		|-> sp_fr.res[30:0] == NAN_SP[30:0] && sp_fr.res[31] == (src1[31] ^ src2[31]))
		else $error("NaN source did not give signed canonical NaN");
	signalling_nan_flag_a: assert property (acc && is_sp && sp_ua.signalling_nan |-> sp_fr.flg.invalid_op_flag)
		else $error("signalling NaN did not raise invalid");
	den_flag_a: assert property (slot_ff[0].vld && slot_ff[0].flg.denormal_source_flag1
		|=> status_ff.denormal_source_flag1)
		else $error("denormal flag not captured in status");

	// special-value results, status capture and idle read data
	zero_inf_a: assert property (acc && is_sp && (((sp_ua.zero || sp_ua.den) && sp_ub.inf)
		|| (sp_ua.inf && (sp_ub.zero || sp_ub.den))) |-> sp_fr.flg.invalid_op_flag && sp_fr.res[30:0] == NAN_SP[30:0])
		else $error("zero times infinity not invalid NaN");
	inf_sign_a: assert property (acc && is_sp && sp_ua.inf && !sp_ub.nan && !sp_ub.zero && !sp_ub.den
		|-> sp_fr.res[30:0] == INF_SP && sp_fr.res[31] == (src1[31] ^ src2[31]))
		else $error("infinity product not signed infinity");
	den_zero_a: assert property (acc && is_sp && sp_ua.den && !sp_ub.inf && !sp_ub.nan
		|-> sp_fr.res[30:0] == 31'h0 && sp_fr.flg.denormal_source_flag1)
		else $error("denormal source not read as zero");
	dp_nan_a: assert property (db_go && (db_ua.nan || db_ub.nan)
		|-> db_fr.res[62:0] == NAN_DP[62:0] && db_fr.res[63] == (src1[31] ^ src2[31]))
		else $error("double NaN source did not give signed canonical NaN");
	flag_set_a: assert property (slot_ff[0].vld && slot_ff[0].flg.invalid_op_flag |=> status_ff.invalid_op_flag)
		else $error("invalid flag lost against a clear");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
		else $error("read data not zero outside a read");

	cov_dp: cover property (acc && iss.cond && is_dp ##9 wb_ff.en);
	cov_full: cover property (acc && iss.cond && is_full ##9 wb_ff.en);
	cov_sp_b2b: cover property (acc && is_sp ##1 acc && is_sp);
	cov_irq: cover property (!irq_ff ##1 irq_ff);
	cov_pred: cover property (acc && !iss.cond ##3 !wb_ff.en);
endmodule : fmu_top

// [test/fmu_rf_model.sv]
`timescale 1ns/100ps
// register file on the far side of the write port
module fmu_rf_model
	import fmu_pkg::*;
(
	// clock and write port
	input wire logic clk_sys,
	input wire fmu_wb_t wb
);
	logic [31:0] regs [32];
	// a word lands at the edge after its strobe; an unknown strobe writes nothing
	always @(posedge clk_sys)
		if (wb.en === 1'b1)
			regs[wb.idx] <= wb.data;
endmodule : fmu_rf_model

// [test/fp_int_multiply_unit_bench.sv]
`timescale 1ns/100ps
module fp_int_multiply_unit_bench
	import fmu_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	fmu_issue_t iss = '0;
	logic [31:0] src1 = '0;
	logic [31:0] src2 = '0;
	logic [3:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	fmu_st_t st;
	logic busy;
	fmu_wb_t wb;
	logic [31:0] rdata;
	logic irq;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [63:0] a;
	logic [63:0] b;
	logic [31:0] s;
	logic uc;
	fmu_op_t op;
	// single cases: src1, src2, product, status bits
	logic [31:0] tab [12][4] = '{
		'{32'h7fc0_0000, 32'hbf80_0000, 32'hffff_ffff, 32'h0000_0000},
		'{32'h7f80_0001, 32'h3f80_0000, 32'h7fff_ffff, 32'h0000_0001},
		'{32'hff80_0000, 32'h4000_0000, 32'hff80_0000, 32'h0000_0000},
		'{32'h7f80_0000, 32'hff80_0000, 32'hff80_0000, 32'h0000_0000},
		'{32'h8000_0000, 32'h7f80_0000, 32'hffff_ffff, 32'h0000_0001},
		'{32'h0000_0000, 32'hc000_0000, 32'h8000_0000, 32'h0000_0000},
		'{32'h0000_0001, 32'h4000_0000, 32'h0000_0000, 32'h0000_0006},
		'{32'hff80_0000, 32'h0040_0000, 32'hffff_ffff, 32'h0000_0009},
		'{32'h3f80_0001, 32'h3f80_0001, 32'h3f80_0002, 32'h0000_0002},
		'{32'h3fc0_0000, 32'h4000_0000, 32'h4040_0000, 32'h0000_0000},
		'{32'h3fc0_0000, 32'h3fc0_0000, 32'h4010_0000, 32'h0000_0000},
		'{32'h8000_0001, 32'h0000_0000, 32'h8000_0000, 32'h0000_0004}};

	// 100 ns period
	always #50 clk_sys = ~clk_sys;

	fmu_top uut (.clk_sys(clk_sys), .nrst(nrst), .iss(iss), .src1(src1), .src2(src2), .st_ff(st),
		.busy_ff(busy), .wb_ff(wb), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_ff(rdata), .irq_ff(irq));
	fmu_rf_model rf (.clk_sys(clk_sys), .wb(wb));

	// signed 64-bit product, sign extension done before the multiply
	function automatic logic [63:0] imul(logic [31:0] x, logic [31:0] y);
		logic signed [63:0] p;
		logic signed [63:0] q;
		p = $signed(x);
		q = $signed(y);
		return p * q;
	endfunction : imul

	task automatic chk(string n, logic [63:0] e, logic [63:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(logic [3:0] ad, logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(logic [3:0] ad, logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("rdata", e, rdata);
	endtask : rd

	// one issue; high halves go out at E4, words checked in the cycle they stand
	task automatic run(fmu_op_t o, logic cnd, logic [4:0] d, logic [63:0] x, logic [63:0] y, logic u,
		logic [63:0] e);
		int lat;
		logic two;
		logic [4:0] i0;
		fmu_st_t est;
		lat = (o == FMU_MUL_SINGLE_FP) ? 3 : 8;
		two = o inside {FMU_MUL_DOUBLE_FP, FMU_MUL_INT_FULL_PAIR};
		i0 = two ? {d[4:1], 1'b0} : d;
		@(posedge clk_sys);
		iss <= '{1'b1, o, cnd, d, u, x[4:0]};
		src1 <= x[31:0];
		src2 <= y[31:0];
		for (int i = 1; i <= lat; i++)
		begin
			@(posedge clk_sys);
			iss.vld <= 1'b0;
			if (i == 3)
			begin
				src1 <= x[63:32];
				src2 <= y[63:32];
			end
			@(negedge clk_sys);
			if (i < 5)
			begin
				chk("busy", (o != FMU_MUL_SINGLE_FP) && i < 4, busy);
				est = (i == 1) ? FMU_E2 : (i == 2) ? FMU_E3 : FMU_E4;
				chk("st", (o == FMU_MUL_SINGLE_FP || i == 4) ? FMU_IDLE : est, st);
			end
		end
		chk("wb_en", cnd, wb.en);
		if (cnd)
		begin
			chk("wb_idx", i0, wb.idx);
			chk("wb_lo", e[31:0], wb.data);
		end
		if (two)
		begin
			@(negedge clk_sys);
			chk("wb_en_hi", cnd, wb.en);
			if (cnd)
			begin
				chk("wb_idx_hi", {i0[4:1], 1'b1}, wb.idx);
				chk("wb_hi", e[63:32], wb.data);
			end
		end
		@(negedge clk_sys);
		if (cnd)
			chk("rf", two ? e : {32'h0, e[31:0]}, two ? {rf.regs[{i0[4:1], 1'b1}], rf.regs[i0]} : {32'h0, rf.regs[i0]});
	endtask : run

	task automatic summarize();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// hang guard, far beyond the length of the sequence
	initial
	begin
		#2_000_000;
		error_cnt++;
		summarize();
	end

	// main sequence: registers, special cases, double, predicate, random integers
	initial
	begin
		void'($urandom(32'hac9d));
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(REG_STATUS, 32'h0000_0000);
		rd(REG_MASK, 32'h0000_0000);
		rd(4'h8, 32'h0000_0000);
		wr(REG_MASK, 32'h0000_0001);
		wr(4'hc, 32'hffff_ffff);
		rd(REG_MASK, 32'h0000_0001);
		for (int k = 0; k < 12; k++)
		begin
			run(FMU_MUL_SINGLE_FP, 1'b1, 5'(k), tab[k][0], tab[k][1], 1'b0, tab[k][2]);
			rd(REG_STATUS, tab[k][3]);
			chk("irq", tab[k][3][0], irq);
			// clear, then look once the registered irq has settled
			wr(REG_STATUS, 32'h0000_000f);
			@(negedge clk_sys);
			chk("irq_clr", 1'b0, irq);
			rd(REG_STATUS, 32'h0000_0000);
		end
		run(FMU_MUL_DOUBLE_FP, 1'b1, 5'h0b, 64'h3ff8_0000_0000_0000, 64'hc004_0000_0000_0000, 1'b0,
			64'hc00e_0000_0000_0000);
		run(FMU_MUL_DOUBLE_FP, 1'b1, 5'h0c, 64'h7ff8_0000_0000_0000, 64'hbff0_0000_0000_0000, 1'b0,
			64'hffff_ffff_ffff_ffff);
		run(FMU_MUL_DOUBLE_FP, 1'b1, 5'h0e, 64'h3ff8_0000_0000_0000, 64'h3ff8_0000_0000_0000, 1'b0,
			64'h4002_0000_0000_0000);
		rd(REG_STATUS, 32'h0000_0000);
		run(FMU_MUL_SINGLE_FP, 1'b0, 5'h05, 64'h7f80_0001, 64'h0000_0001, 1'b0, 64'h0);
		run(FMU_MUL_INT_FULL_PAIR, 1'b0, 5'h06, 64'h5, 64'h7, 1'b0, 64'h0);
		rd(REG_STATUS, 32'h0000_0000);
		for (int k = 0; k < 8; k++)
		begin
			a = k ? $urandom() : 32'h8000_0000;
			b = k ? $urandom() : 32'hffff_ffff;
			uc = k ? 1'($urandom_range(1)) : 1'b0;
			op = $urandom_range(1) ? FMU_MUL_INT_FULL_PAIR : FMU_MUL_INT_LOW_WORD;
			s = uc ? {{27{a[4]}}, a[4:0]} : a[31:0];
			run(op, 1'b1, 5'($urandom()), a, b, uc, imul(s, b[31:0]));
		end
		summarize();
	end
endmodule : fp_int_multiply_unit_bench
